// file: filt_input_defines.svh
// constants for the four channel filtered input module
`ifndef FILT_INPUT_DEFINES_SVH
`define FILT_INPUT_DEFINES_SVH
`define NUM_CHANNELS 4
`define INPUT_IMAGE_OFFSET 8'h00
`define IMAGE_RESERVED_MASK 8'hf0
`define FILTER_CODE_RESET 8'h02
`define FILTER_CODE_1US 8'h00
`define FILTER_CODE_3US 8'h02
`define FILTER_CODE_10US 8'h04
`define FILTER_CODE_86US 8'h07
`define FILTER_CODE_342US 8'h09
`define FILTER_CODE_2731US 8'h0c
`define EDGE_MASK_RESET 4'h0
`define DIAG_ENABLE_CODE 8'h40
`define CLK_PERIOD_NS 10
`define FILTER_1US_NS 1000
`define FILTER_3US_NS 3000
`define FILTER_10US_NS 10000
`define FILTER_86US_NS 86000
`define FILTER_342US_NS 342000
`define FILTER_2731US_NS 2731000
`define BLINK_FREQ_HZ 2
`define BLINK_HALF_CYCLES (1000000000 / (`CLK_PERIOD_NS * `BLINK_FREQ_HZ * 2))
`define CYC(ns) ((ns) / `CLK_PERIOD_NS)
`endif

// file: filt_input_pkg.sv
// types for the four channel filtered input module
package filt_input_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [3:0] chan_t;
    typedef logic [18:0] filt_count_t;
    typedef enum logic [1:0] {LED_OFF, LED_ON, LED_BLINK} led_mode_e;
endpackage

// file: chan_filter_if.sv
// per-channel filter setting and result between top and filter
interface chan_filter_if;
    import filt_input_pkg::*;
    filt_count_t limit;
    logic raw;
    logic filtered;
    logic rise;
    logic fall;
    modport top (output limit, output raw, input filtered, input rise, input fall);
    modport filt (input limit, input raw, output filtered, output rise, output fall);
endinterface

// file: chan_filter.sv
// one input channel debounce filter with edge pulses
module chan_filter (
    input wire logic clk,
    input wire logic rst,
    chan_filter_if.filt ch
);
    import filt_input_pkg::*;
    filt_count_t count_reg;
    logic state_reg;
    logic rise_reg;
    logic fall_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            state_reg <= 1'b0;
        end else if (ch.raw == state_reg) begin
            count_reg <= '0;
        end else if (count_reg + 19'd1 >= ch.limit) begin
            count_reg <= '0;
            state_reg <= ch.raw;
        end else begin
            count_reg <= count_reg + 19'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rise_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            rise_reg <= (ch.raw != state_reg) && (count_reg + 19'd1 >= ch.limit) && ch.raw;
            fall_reg <= (ch.raw != state_reg) && (count_reg + 19'd1 >= ch.limit) && !ch.raw;
        end
    end

    assign ch.filtered = state_reg;
    assign ch.rise = rise_reg;
    assign ch.fall = fall_reg;
endmodule

// file: filt_input_top.sv
// four channel filtered input module top
// Functional notes
// - the one-byte input image holds filtered channels 0 to 3 in bits 0 to 3.
// - the input image is read by the head unit at byte offset zero of its input area.
// - the module takes no output bytes; output-area traffic is ignored.
// - each channel indicator follows its filtered input when run is lit and fault dark.
// - working bus and no error light run and keep fault dark.
// - working bus with internal error light run and fault steadily.
// - failed bus with error turns run off and lights fault steadily.
// - bus power failure turns both run and fault off.
// - a configuration error blinks the fault indicator at 2 Hz.
// - each channel filters rising and falling transitions by a settable delay.
// - process and diagnostic interrupts are each enabled by configuration.
// - channel indicators keep showing inputs while electronic power is off.
// - the filter setting is a byte code; only 00h,02h,04h,07h,09h,0ch are legal, default 02h.
// - rising and falling edge masks in bits 0 to 3 choose which edges raise events.
`include "filt_input_defines.svh"
module filt_input_top (
    input wire logic clk,
    input wire logic rst,
    input wire filt_input_pkg::chan_t input_channel,
    input wire logic bus_ok,
    input wire logic bus_power_ok,
    input wire logic internal_error,
    input wire logic electronic_power_on,
    input wire logic cfg_we,
    input wire logic [1:0] cfg_chan,
    input wire filt_input_pkg::byte_t cfg_filter_code,
    input wire filt_input_pkg::chan_t cfg_rise_mask,
    input wire filt_input_pkg::chan_t cfg_fall_mask,
    input wire filt_input_pkg::byte_t cfg_diag_enable,
    input wire logic cfg_proc_enable,
    input wire logic img_rd,
    input wire filt_input_pkg::byte_t img_addr,
    input wire logic out_wr,
    input wire filt_input_pkg::byte_t out_data,
    output filt_input_pkg::byte_t input_image,
    output filt_input_pkg::byte_t rd_data,
    output logic rd_valid,
    output filt_input_pkg::chan_t channel_led,
    output logic run_indicator,
    output logic fault_indicator,
    output logic process_event,
    output filt_input_pkg::chan_t process_edges,
    output filt_input_pkg::byte_t process_state,
    output logic diag_event,
    output logic config_error
);
    import filt_input_pkg::*;

    byte_t filter_code_reg [`NUM_CHANNELS];
    chan_t rising_edge_enable_mask_reg;
    chan_t falling_edge_enable_mask_reg;
    logic diag_en_reg;
    logic proc_en_reg;
    logic cfg_err_reg;
    chan_t filtered;
    chan_t rise;
    chan_t fall;
    byte_t input_image_reg;
    byte_t rd_data_reg;
    logic rd_valid_reg;
    chan_t led_reg;
    logic run_reg;
    logic fault_reg;
    logic blink_reg;
    logic [24:0] blink_cnt_reg;
    logic proc_evt_reg;
    chan_t proc_edges_reg;
    byte_t proc_state_reg;
    logic diag_evt_reg;
    logic proc_pending_reg;
    chan_t hits;

    function automatic logic code_legal(input byte_t c);
        return c == `FILTER_CODE_1US || c == `FILTER_CODE_3US || c == `FILTER_CODE_10US ||
            c == `FILTER_CODE_86US || c == `FILTER_CODE_342US || c == `FILTER_CODE_2731US;
    endfunction

    function automatic filt_count_t code_cycles(input byte_t c);
        case (c)
            `FILTER_CODE_1US: code_cycles = 19'(`CYC(`FILTER_1US_NS));
            `FILTER_CODE_3US: code_cycles = 19'(`CYC(`FILTER_3US_NS));
            `FILTER_CODE_10US: code_cycles = 19'(`CYC(`FILTER_10US_NS));
            `FILTER_CODE_86US: code_cycles = 19'(`CYC(`FILTER_86US_NS));
            `FILTER_CODE_342US: code_cycles = 19'(`CYC(`FILTER_342US_NS));
            `FILTER_CODE_2731US: code_cycles = 19'(`CYC(`FILTER_2731US_NS));
            default: code_cycles = 19'(`CYC(`FILTER_3US_NS));
        endcase
    endfunction

    // filter code store, illegal codes rejected
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `NUM_CHANNELS; i++) begin
                filter_code_reg[i] <= `FILTER_CODE_RESET;
            end
            cfg_err_reg <= 1'b0;
        end else if (cfg_we) begin
            if (code_legal(cfg_filter_code)) begin
                filter_code_reg[cfg_chan] <= cfg_filter_code;
                cfg_err_reg <= 1'b0;
            end else begin
                cfg_err_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rising_edge_enable_mask_reg <= `EDGE_MASK_RESET;
            falling_edge_enable_mask_reg <= `EDGE_MASK_RESET;
            diag_en_reg <= 1'b0;
            proc_en_reg <= 1'b0;
        end else if (cfg_we) begin
            rising_edge_enable_mask_reg <= cfg_rise_mask;
            falling_edge_enable_mask_reg <= cfg_fall_mask;
            diag_en_reg <= cfg_diag_enable == `DIAG_ENABLE_CODE;
            proc_en_reg <= cfg_proc_enable;
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_CHANNELS; g++) begin : gen_ch
            chan_filter_if cif ();
            assign cif.limit = code_cycles(filter_code_reg[g]);
            assign cif.raw = input_channel[g];
            assign filtered[g] = cif.filtered;
            assign rise[g] = cif.rise;
            assign fall[g] = cif.fall;
            chan_filter u_filt (.clk(clk), .rst(rst), .ch(cif));
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            input_image_reg <= 8'h00;
        end else begin
            input_image_reg <= {4'h0, filtered} & ~`IMAGE_RESERVED_MASK;
        end
    end

    // image read at offset zero, output writes ignored
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= img_rd;
            rd_data_reg <= (img_rd && img_addr == `INPUT_IMAGE_OFFSET) ? input_image_reg : 8'h00;
        end
    end

    assign hits = (rise & rising_edge_enable_mask_reg) | (fall & falling_edge_enable_mask_reg);

    always_ff @(posedge clk) begin
        if (rst) begin
            proc_evt_reg <= 1'b0;
            proc_edges_reg <= 4'h0;
            proc_state_reg <= 8'h00;
            proc_pending_reg <= 1'b0;
            diag_evt_reg <= 1'b0;
        end else begin
            proc_evt_reg <= proc_en_reg && hits != 4'h0;
            diag_evt_reg <= diag_en_reg && proc_pending_reg && hits != 4'h0;
            proc_pending_reg <= proc_en_reg && hits != 4'h0;
            if (proc_en_reg && hits != 4'h0) begin
                proc_edges_reg <= hits;
                proc_state_reg <= {4'h0, filtered};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            blink_cnt_reg <= '0;
            blink_reg <= 1'b0;
        end else if (blink_cnt_reg == 25'(`BLINK_HALF_CYCLES - 1)) begin
            blink_cnt_reg <= '0;
            blink_reg <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 25'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else if (!bus_power_ok) begin
            run_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            run_reg <= bus_ok;
            if (cfg_err_reg) begin
                fault_reg <= blink_reg;
            end else begin
                fault_reg <= internal_error || !bus_ok;
            end
        end
    end

    // channel leds follow filtered inputs regardless of electronic power
    always_ff @(posedge clk) begin
        if (rst) begin
            led_reg <= 4'h0;
        end else begin
            led_reg <= filtered;
        end
    end

    assign input_image = input_image_reg;
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign channel_led = led_reg;
    assign run_indicator = run_reg;
    assign fault_indicator = fault_reg;
    assign process_event = proc_evt_reg;
    assign process_edges = proc_edges_reg;
    assign process_state = proc_state_reg;
    assign diag_event = diag_evt_reg;
    assign config_error = cfg_err_reg;
endmodule

// file: filt_input_top_asserts.sv
// port assertions for the filtered input module
module filt_input_asserts
    import filt_input_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic bus_ok,
    input wire logic bus_power_ok,
    input wire logic internal_error,
    input wire logic cfg_we,
    input wire byte_t cfg_filter_code,
    input wire logic img_rd,
    input wire byte_t img_addr,
    input wire byte_t input_image,
    input wire byte_t rd_data,
    input wire logic rd_valid,
    input wire chan_t channel_led,
    input wire logic run_indicator,
    input wire logic fault_indicator,
    input wire logic process_event,
    input wire byte_t process_state,
    input wire logic config_error
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rsv; input_image[7:4] == 4'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_led; channel_led == input_image[3:0]; endproperty
    a_led: assert property (p_led) else $error("led differs");
    property p_rd; img_rd && img_addr == 8'h00 |=> rd_valid && rd_data == $past(input_image);
    endproperty
    a_rd: assert property (p_rd) else $error("bad read");
    property p_pwr; !bus_power_ok |=> !run_indicator && !fault_indicator; endproperty
    a_pwr: assert property (p_pwr) else $error("power fail leds");
    property p_run; bus_power_ok |=> run_indicator == $past(bus_ok); endproperty
    a_run: assert property (p_run) else $error("run wrong");
    property p_fault; bus_power_ok && !config_error && !cfg_we
        |=> fault_indicator == $past(internal_error || !bus_ok); endproperty
    a_fault: assert property (p_fault) else $error("fault wrong");
    property p_cfg; cfg_we && !(cfg_filter_code inside {8'h00, 8'h02, 8'h04, 8'h07, 8'h09,
        8'h0c}) |=> config_error; endproperty
    a_cfg: assert property (p_cfg) else $error("bad code taken");
    property p_ev; process_event |-> process_state == input_image; endproperty
    a_ev: assert property (p_ev) else $error("event state");
endmodule

// file: head_unit_model.sv
// head unit model: configuration writes and image reads
module head_unit_model
    import filt_input_pkg::*;
(
    input wire logic clk,
    input wire byte_t rd_data,
    input wire logic rd_valid,
    output logic cfg_we,
    output logic [1:0] cfg_chan,
    output byte_t cfg_filter_code,
    output chan_t cfg_rise_mask,
    output chan_t cfg_fall_mask,
    output byte_t cfg_diag_enable,
    output logic cfg_proc_enable,
    output logic img_rd,
    output byte_t img_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {cfg_we, cfg_chan, cfg_filter_code, cfg_rise_mask, cfg_fall_mask} = '0;
        {cfg_diag_enable, cfg_proc_enable, img_rd, img_addr} = '0;
    end
    task automatic write_cfg(input logic [1:0] ch, input byte_t code, input chan_t rm,
        input chan_t fm);
        @(posedge clk) #1;
        {cfg_we, cfg_chan, cfg_filter_code, cfg_rise_mask, cfg_fall_mask} =
            {1'b1, ch, code, rm, fm};
        {cfg_diag_enable, cfg_proc_enable} = {8'h40, 1'b1};
        @(posedge clk) #1;
        cfg_we = 1'b0;
    endtask
    // byte read of the input area
    task automatic read_img(input byte_t addr, output byte_t data);
        @(posedge clk) #1;
        {img_rd, img_addr} = {1'b1, addr};
        @(posedge clk) #1;
        img_rd = 1'b0;
        img_addr = ~addr;
        data = rd_valid ? rd_data : 8'hxx;
    endtask
endmodule

// file: tb_filt_input_top.sv
// testbench for the four channel filtered input module
module tb_filt_input_top;
    timeunit 1ns;
    timeprecision 1ps;
    import filt_input_pkg::*;
    logic clk, rst, bus_ok, bus_power_ok, internal_error, electronic_power_on, out_wr, cfg_we;
    logic rd_valid, run_indicator, fault_indicator, process_event, diag_event, config_error;
    logic cfg_proc_enable, img_rd;
    logic [1:0] cfg_chan;
    chan_t input_channel, cfg_rise_mask, cfg_fall_mask, channel_led, process_edges;
    byte_t out_data, input_image, rd_data, process_state, cfg_filter_code, cfg_diag_enable;
    byte_t img_addr;
    int miscompares = 0;
    int num_checks = 0;
    filt_input_top DUT (.clk(clk), .rst(rst), .input_channel(input_channel), .bus_ok(bus_ok),
        .bus_power_ok(bus_power_ok), .internal_error(internal_error),
        .electronic_power_on(electronic_power_on), .cfg_we(cfg_we), .cfg_chan(cfg_chan),
        .cfg_filter_code(cfg_filter_code), .cfg_rise_mask(cfg_rise_mask),
        .cfg_fall_mask(cfg_fall_mask), .cfg_diag_enable(cfg_diag_enable),
        .cfg_proc_enable(cfg_proc_enable), .img_rd(img_rd), .img_addr(img_addr),
        .out_wr(out_wr), .out_data(out_data), .input_image(input_image), .rd_data(rd_data),
        .rd_valid(rd_valid), .channel_led(channel_led), .run_indicator(run_indicator),
        .fault_indicator(fault_indicator), .process_event(process_event),
        .process_edges(process_edges), .process_state(process_state),
        .diag_event(diag_event), .config_error(config_error));
    head_unit_model hu (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .cfg_we(cfg_we),
        .cfg_chan(cfg_chan), .cfg_filter_code(cfg_filter_code), .cfg_rise_mask(cfg_rise_mask),
        .cfg_fall_mask(cfg_fall_mask), .cfg_diag_enable(cfg_diag_enable),
        .cfg_proc_enable(cfg_proc_enable), .img_rd(img_rd), .img_addr(img_addr));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (miscompares == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_event(input int lim);
        for (int i = 0; i < lim && process_event !== 1'b1; i++) @(posedge clk) #1;
        if (process_event !== 1'b1) begin
            check({7'h0, process_event}, 8'h01);
            complete_run();
        end
    endtask
    task automatic t_filter;
        byte_t d;
        for (int c = 0; c < 4; c++) hu.write_cfg(c[1:0], 8'h00, 4'h5, 4'h2);
        {out_wr, out_data, input_channel} = {1'b1, 8'hff, 4'hf};
        repeat (90) @(posedge clk) #1;
        input_channel = 4'h0;
        repeat (120) @(posedge clk) #1;
        check(input_image, 8'h00);
        input_channel = 4'hf;
        repeat (99) @(posedge clk) #1;
        check(input_image, 8'h00);
        wait_event(6);
        check({4'h0, process_edges}, 8'h05);
        check(process_state, 8'h0f);
        check({7'h0, diag_event}, 8'h00);
        check(input_image, 8'h0f);
        check({4'h0, channel_led}, 8'h0f);
        hu.read_img(8'h00, d);
        check(d, 8'h0f);
        hu.read_img(8'h01, d);
        check(d, 8'h00);
        input_channel = 4'h0;
        wait_event(110);
        check({4'h0, process_edges}, 8'h02);
        check(process_state, 8'h00);
    endtask
    task automatic t_diag;
        input_channel = 4'h1;
        @(posedge clk) #1;
        input_channel = 4'h5;
        wait_event(110);
        check({4'h0, process_edges}, 8'h01);
        @(posedge clk) #1;
        check({7'h0, process_event}, 8'h01);
        check({4'h0, process_edges}, 8'h04);
        check({7'h0, diag_event}, 8'h01);
    endtask
    task automatic t_leds;
        logic [2:0] st [4] = '{3'b110, 3'b111, 3'b101, 3'b011};
        logic [1:0] ex [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
        for (int i = 0; i < 4; i++) begin
            {bus_power_ok, bus_ok, internal_error} = st[i];
            repeat (3) @(posedge clk) #1;
            check({6'h0, run_indicator, fault_indicator}, {6'h0, ex[i]});
        end
        {bus_power_ok, bus_ok, internal_error} = 3'b110;
    endtask
    task automatic t_cfgerr;
        byte_t codes [6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0c};
        logic f;
        hu.write_cfg(2'h1, 8'h03, 4'h0, 4'h0);
        check({7'h0, config_error}, 8'h01);
        repeat (2) @(posedge clk) #1;
        check({7'h0, run_indicator}, 8'h01);
        f = fault_indicator;
        internal_error = 1'b1;
        repeat (3) @(posedge clk) #1;
        check({7'h0, fault_indicator}, {7'h0, f});
        internal_error = 1'b0;
        for (int i = 0; i < 6; i++) begin
            hu.write_cfg(2'h0, codes[i], 4'h0, 4'h0);
            check({7'h0, config_error}, 8'h00);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst, bus_ok, bus_power_ok, internal_error, electronic_power_on} = 5'b11100;
        {out_wr, out_data, input_channel} = '0;
        repeat (4) @(posedge clk);
        #1 rst = 1'b0;
        check(input_image, 8'h00);
        t_filter();
        t_diag();
        t_leds();
        t_cfgerr();
        complete_run();
    end
endmodule
bind filt_input_top filt_input_asserts u_chk (.clk(clk), .rst(rst), .bus_ok(bus_ok),
    .bus_power_ok(bus_power_ok), .internal_error(internal_error), .cfg_we(cfg_we),
    .cfg_filter_code(cfg_filter_code), .img_rd(img_rd), .img_addr(img_addr),
    .input_image(input_image), .rd_data(rd_data), .rd_valid(rd_valid),
    .channel_led(channel_led), .run_indicator(run_indicator),
    .fault_indicator(fault_indicator), .process_event(process_event),
    .process_state(process_state), .config_error(config_error));
